// [rtl/nsapp_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Status mode holds until new command; page read command resumes array output.
// - Host follows enhanced status command with three row address cycles.
// - Host issues read mode command to read data after a read completes.
// - Host never issues enhanced status while one-time-programmable mode is on.
// - Host XORs id copy with complement; accepts only all ones, else next.
// - Host programs pages of a block in ascending order only.
// - Host limits a page to four partial program passes before erase.
// - Program: data-input command, five address cycles, data bytes, confirm command.
// - While program busy only status and reset commands are issued.
// - Before confirm, random data input command may change column repeatedly.
module nsapp_ctrl
  import nsapp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire nsapp_req_t req_i,
  output logic req_ready_o,
  output logic req_error_o,
  output logic busy_o,
  input wire logic write_protect_i,
  output logic [7:0] status_byte_o,
  output logic status_valid_o,
  output logic status_fail_o,
  output logic status_fail_prev_o,
  output logic array_ready_o,
  output logic cache_ready_o,
  output logic unprotected_o,
  output logic status_rsvd_err_o,
  output logic status_mode_o,
  output logic device_ready_o,
  output logic id_done_o,
  output logic id_ok_o,
  input wire logic [3:0] id_rd_idx_i,
  output logic [7:0] id_rd_data_o,
  output nsapp_pins_t pins_o,
  input wire logic [7:0] io_i,
  input wire logic ready_busy_pin_i
);

  // ----------------------------------------
  // Sequence of bus cycles per operation
  // ----------------------------------------
  function automatic nsapp_step_t step_at(input nsapp_op_t op, input logic [3:0] i,
                                          input nsapp_req_t q);
    nsapp_step_t s;
    s = '{K_END, 8'h00};
    unique case (op)
      OP_STATUS: begin
        if (i == 4'h0) s = '{K_CMD, CMD_STATUS};
        else if (i == 4'h1) s = '{K_READ, 8'h00};
      end
      OP_ENH_STATUS: begin
        case (i)
          4'h0: s = '{K_CMD, CMD_ENH_STATUS};
          4'h1: s = '{K_ADDR, q.row[7:0]};
          4'h2: s = '{K_ADDR, q.row[15:8]};
          4'h3: s = '{K_ADDR, q.row[23:16]};
          4'h4: s = '{K_READ, 8'h00};
          default: s = '{K_END, 8'h00};
        endcase
      end
      OP_PROG_BEGIN: begin
        case (i)
          4'h0: s = '{K_CMD, CMD_SERIAL_IN};
          4'h1: s = '{K_ADDR, q.col[7:0]};
          4'h2: s = '{K_ADDR, q.col[15:8]};
          4'h3: s = '{K_ADDR, q.row[7:0]};
          4'h4: s = '{K_ADDR, q.row[15:8]};
          4'h5: s = '{K_ADDR, q.row[23:16]};
          default: s = '{K_END, 8'h00};
        endcase
      end
      OP_PROG_DATA: begin
        if (i == 4'h0) s = '{K_DATA, q.data};
      end
      OP_RAND_COL: begin
        case (i)
          4'h0: s = '{K_CMD, CMD_RAND_IN};
          4'h1: s = '{K_ADDR, q.col[7:0]};
          4'h2: s = '{K_ADDR, q.col[15:8]};
          default: s = '{K_END, 8'h00};
        endcase
      end
      OP_PROG_CONFIRM: begin
        case (i)
          4'h0: s = '{K_CMD, CMD_PROG};
          4'h1: s = '{K_WAIT, 8'h00};
          4'h2: s = '{K_CMD, CMD_STATUS};
          4'h3: s = '{K_READ, 8'h00};
          default: s = '{K_END, 8'h00};
        endcase
      end
      OP_READ_MODE: begin
        if (i == 4'h0) s = '{K_CMD, CMD_READ_MODE};
      end
      OP_RESET: begin
        if (i == 4'h0) s = '{K_CMD, CMD_RESET};
        else if (i == 4'h1) s = '{K_WAIT, 8'h00};
      end
      OP_ID_CHECK: begin
        case (i)
          4'h0: s = '{K_CMD, CMD_ID_PAGE};
          4'h1: s = '{K_ADDR, ADDR_ID_PAGE};
          4'h2: s = '{K_WAIT, 8'h00};
          4'h3: s = '{K_IDLOOP, 8'h00};
          default: s = '{K_END, 8'h00};
        endcase
      end
      default: s = '{K_END, 8'h00};
    endcase
    return s;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  nsapp_ctl_t r;
  nsapp_ctl_t next_r;
  nsapp_step_t step;
  logic allowed;
  logic same_blk;
  logic [7:0] mem_rd;
  logic mem_we;
  logic [3:0] mem_rd_addr;

  // Only status and reset may go out while the device is busy
  assign allowed = r.rb_sync || req_i.op == OP_STATUS || req_i.op == OP_RESET;
  assign req_ready_o = (r.st == ST_IDLE) && allowed;
  assign same_blk = r.last_valid && (r.last_blk == req_i.row[23:ROW_PAGE_W]);
  assign step = step_at(r.req.op, r.idx, r.req);
  assign mem_we = (r.st == ST_RD_LOW) && (r.cnt == 8'h01) && r.rd_is_id && !r.id_byte[4];
  assign mem_rd_addr = (r.st == ST_RD_LOW && r.rd_is_id) ? r.id_byte[3:0] : id_rd_idx_i;

  nsapp_id_mem u_id_mem (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(mem_we),
    .wr_addr_i(r.id_byte[3:0]),
    .wr_data_i(r.io_sync),
    .rd_addr_i(mem_rd_addr),
    .rd_data_o(mem_rd)
  );

  always_comb begin
    next_r = r;
    next_r.rb_meta = ready_busy_pin_i;
    next_r.rb_sync = r.rb_meta;
    next_r.io_meta = io_i;
    next_r.io_sync = r.io_meta;
    next_r.pins.wp_n = !write_protect_i;
    next_r.status_valid = 1'b0;
    next_r.req_error = 1'b0;
    next_r.id_done = 1'b0;
    unique case (r.st)
      ST_IDLE: begin
        if (req_valid_i && allowed) begin
          if (req_i.op == OP_PROG_BEGIN && same_blk
              && req_i.row[ROW_PAGE_W-1:0] < r.last_page) begin
            next_r.req_error = 1'b1;
          end else if (req_i.op == OP_PROG_BEGIN && same_blk
                       && req_i.row[ROW_PAGE_W-1:0] == r.last_page
                       && r.passes >= MAX_PASSES) begin
            next_r.req_error = 1'b1;
          end else begin
            if (req_i.op == OP_PROG_BEGIN) begin
              next_r.passes = (same_blk && req_i.row[ROW_PAGE_W-1:0] == r.last_page)
                              ? r.passes + 3'h1 : 3'h1;
              next_r.last_blk = req_i.row[23:ROW_PAGE_W];
              next_r.last_page = req_i.row[ROW_PAGE_W-1:0];
              next_r.last_valid = 1'b1;
            end
            if (req_i.op == OP_ID_CHECK) begin
              next_r.id_byte = 5'h00;
              next_r.id_copy = 4'h0;
              next_r.id_acc = 1'b1;
              next_r.id_ok = 1'b0;
            end
            next_r.req = req_i;
            next_r.idx = 4'h0;
            next_r.pins.ce_n = 1'b0;
            next_r.st = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        unique case (step.kind)
          K_CMD, K_ADDR, K_DATA: begin
            next_r.pins.cle = (step.kind == K_CMD);
            next_r.pins.ale = (step.kind == K_ADDR);
            next_r.pins.io_out = step.val;
            next_r.pins.io_oe = 1'b1;
            next_r.pins.we_n = 1'b0;
            next_r.cnt = WE_LOW_CYC;
            next_r.st = ST_WR_LOW;
            if (step.kind == K_CMD) begin
              // Any new command ends or enters status mode
              next_r.status_mode = (step.val == CMD_STATUS)
                                   || (step.val == CMD_ENH_STATUS);
            end
          end
          K_READ, K_IDLOOP: begin
            next_r.pins.re_n = 1'b0;
            next_r.rd_is_id = (step.kind == K_IDLOOP);
            next_r.cnt = RD_CYC;
            next_r.st = ST_RD_LOW;
          end
          K_WAIT: begin
            next_r.cnt = WB_CYC;
            next_r.st = ST_BUSY_WAIT;
          end
          K_END: begin
            next_r.pins.ce_n = 1'b1;
            next_r.st = ST_IDLE;
          end
          default: begin
            next_r.pins.ce_n = 1'b1;
            next_r.st = ST_IDLE;
          end
        endcase
      end
      ST_WR_LOW: begin
        if (r.cnt == 8'h01) begin
          next_r.pins.we_n = 1'b1; // Latched on the rising write strobe
          next_r.cnt = WE_HIGH_CYC;
          next_r.st = ST_WR_HIGH;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      ST_WR_HIGH: begin
        if (r.cnt == 8'h01) begin
          next_r.pins.cle = 1'b0;
          next_r.pins.ale = 1'b0;
          next_r.pins.io_oe = 1'b0;
          next_r.idx = r.idx + 4'h1;
          next_r.st = ST_NEXT;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      ST_RD_LOW: begin
        if (r.cnt == 8'h01) begin
          next_r.pins.re_n = 1'b1;
          next_r.cnt = RE_HIGH_CYC;
          next_r.st = ST_RD_HIGH;
          if (!r.rd_is_id) begin
            next_r.status = r.io_sync;
            next_r.status_valid = 1'b1;
            next_r.idx = r.idx + 4'h1;
          end else begin
            next_r.id_byte = r.id_byte + 5'h01;
            if (r.id_byte[4]) begin
              next_r.id_acc = r.id_acc && ((r.io_sync ^ mem_rd) == ID_ALL_ONES);
            end
            if (r.id_byte == ID_LAST_BYTE) begin
              if (next_r.id_acc) begin
                next_r.id_ok = 1'b1;
                next_r.id_done = 1'b1;
                next_r.idx = r.idx + 4'h1;
              end else if (r.id_copy == ID_LAST_COPY) begin
                next_r.id_done = 1'b1;
                next_r.idx = r.idx + 4'h1;
              end else begin
                next_r.id_copy = r.id_copy + 4'h1;
                next_r.id_acc = 1'b1;
              end
            end
          end
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      ST_RD_HIGH: begin
        if (r.cnt == 8'h01) begin
          next_r.st = ST_NEXT;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      ST_BUSY_WAIT: begin
        if (r.cnt > 8'h01) begin
          next_r.cnt = r.cnt - 8'h01;
        end else if (r.rb_sync) begin
          next_r.idx = r.idx + 4'h1;
          next_r.st = ST_NEXT;
        end
      end
      default: begin
        next_r = CTL_RST;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r <= CTL_RST;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign req_error_o = r.req_error;
  assign busy_o = (r.st != ST_IDLE);
  assign status_byte_o = r.status;
  assign status_valid_o = r.status_valid;
  assign status_fail_o = r.status[SB_FAIL] && r.status[SB_ARRAY_RDY];
  assign status_fail_prev_o = r.status[SB_FAIL_PREV] && r.status[SB_CACHE_RDY];
  assign array_ready_o = r.status[SB_ARRAY_RDY];
  assign cache_ready_o = r.status[SB_CACHE_RDY];
  assign unprotected_o = r.status[SB_UNPROT];
  assign status_rsvd_err_o = |(r.status & SB_RSVD_MASK);
  assign status_mode_o = r.status_mode;
  assign device_ready_o = r.rb_sync;
  assign id_done_o = r.id_done;
  assign id_ok_o = r.id_ok;
  assign id_rd_data_o = mem_rd;
  assign pins_o = r.pins;

endmodule // nsapp_ctrl

`default_nettype wire

// [rtl/nsapp_pkg.sv]
package nsapp_pkg;

  // ----------------------------------------
  // Clock and pin timing
  // ----------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int SYNC_STAGES = 2;
  localparam int T_WE_LOW_NS = 25;
  localparam int T_WE_HIGH_NS = 25;
  localparam int T_RE_ACC_NS = 25;
  localparam int T_RE_HIGH_NS = 25;
  localparam int T_WB_NS = 100;

  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [7:0] WE_LOW_CYC = 8'(ns2cyc(T_WE_LOW_NS));
  localparam logic [7:0] WE_HIGH_CYC = 8'(ns2cyc(T_WE_HIGH_NS));
  localparam logic [7:0] RD_CYC = 8'(ns2cyc(T_RE_ACC_NS) + SYNC_STAGES);
  localparam logic [7:0] RE_HIGH_CYC = 8'(ns2cyc(T_RE_HIGH_NS));
  localparam logic [7:0] WB_CYC = 8'(ns2cyc(T_WB_NS));

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ENH_STATUS = 8'h78;
  localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
  localparam logic [7:0] CMD_PROG = 8'h10;
  localparam logic [7:0] CMD_RAND_IN = 8'h85;
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_ID_PAGE = 8'hED;
  localparam logic [7:0] ADDR_ID_PAGE = 8'h00;

  // ----------------------------------------
  // Status byte fields
  // ----------------------------------------
  localparam int SB_FAIL = 0;
  localparam int SB_FAIL_PREV = 1;
  localparam int SB_ARRAY_RDY = 5;
  localparam int SB_CACHE_RDY = 6;
  localparam int SB_UNPROT = 7;
  localparam logic [7:0] SB_RSVD_MASK = 8'h1C;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ----------------------------------------
  // Row layout, program limits, identifier page
  // ----------------------------------------
  localparam int ROW_PAGE_W = 6;
  localparam logic [2:0] MAX_PASSES = 3'h4;
  localparam logic [4:0] ID_LAST_BYTE = 5'h1F;
  localparam logic [3:0] ID_LAST_COPY = 4'hF;
  localparam logic [7:0] ID_ALL_ONES = 8'hFF;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_STATUS = 4'h0,
    OP_ENH_STATUS = 4'h1,
    OP_PROG_BEGIN = 4'h2,
    OP_PROG_DATA = 4'h3,
    OP_RAND_COL = 4'h4,
    OP_PROG_CONFIRM = 4'h5,
    OP_READ_MODE = 4'h6,
    OP_RESET = 4'h7,
    OP_ID_CHECK = 4'h8
  } nsapp_op_t;

  typedef struct packed {
    nsapp_op_t op;
    logic [15:0] col;
    logic [23:0] row;
    logic [7:0] data;
  } nsapp_req_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic io_oe;
    logic [7:0] io_out;
  } nsapp_pins_t;

  typedef enum logic [2:0] {
    K_CMD = 3'h0,
    K_ADDR = 3'h1,
    K_DATA = 3'h2,
    K_READ = 3'h3,
    K_WAIT = 3'h4,
    K_IDLOOP = 3'h5,
    K_END = 3'h6
  } nsapp_kind_t;

  typedef struct packed {
    nsapp_kind_t kind;
    logic [7:0] val;
  } nsapp_step_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_NEXT = 7'b0000010,
    ST_WR_LOW = 7'b0000100,
    ST_WR_HIGH = 7'b0001000,
    ST_RD_LOW = 7'b0010000,
    ST_RD_HIGH = 7'b0100000,
    ST_BUSY_WAIT = 7'b1000000
  } nsapp_state_t;

  typedef struct packed {
    nsapp_state_t st;
    nsapp_req_t req;
    logic [3:0] idx;
    logic [7:0] cnt;
    nsapp_pins_t pins;
    logic rd_is_id;
    logic rb_meta;
    logic rb_sync;
    logic [7:0] io_meta;
    logic [7:0] io_sync;
    logic [7:0] status;
    logic status_valid;
    logic status_mode;
    logic req_error;
    logic [4:0] id_byte;
    logic [3:0] id_copy;
    logic id_acc;
    logic id_ok;
    logic id_done;
    logic [17:0] last_blk;
    logic [5:0] last_page;
    logic last_valid;
    logic [2:0] passes;
  } nsapp_ctl_t;

  localparam nsapp_pins_t PINS_RST = '{
    ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
    wp_n: 1'b0, io_oe: 1'b0, io_out: 8'h00};

  localparam nsapp_ctl_t CTL_RST = '{
    st: ST_IDLE, req: '0, idx: 4'h0, cnt: 8'h00, pins: PINS_RST,
    rd_is_id: 1'b0, rb_meta: 1'b0, rb_sync: 1'b0, io_meta: 8'h00,
    io_sync: 8'h00, status: STATUS_RST, status_valid: 1'b0,
    status_mode: 1'b0, req_error: 1'b0, id_byte: 5'h00, id_copy: 4'h0,
    id_acc: 1'b0, id_ok: 1'b0, id_done: 1'b0, last_blk: 18'h00000,
    last_page: 6'h00, last_valid: 1'b0, passes: 3'h0};

endpackage

// [rtl/nsapp_id_mem.sv]
`timescale 1ns/1ps
`default_nettype none

module nsapp_id_mem
  import nsapp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [3:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [7:0] rd_data;
  } nsapp_mem_t;

  nsapp_mem_t r;
  nsapp_mem_t next_r;

  always_comb begin
    next_r = r;
    if (wr_en_i) begin
      next_r.mem[wr_addr_i] = wr_data_i;
    end
    next_r.rd_data = r.mem[rd_addr_i];
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rd_data_o = r.rd_data;

endmodule // nsapp_id_mem

`default_nettype wire

// [sim/nsapp_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module nsapp_ctrl_assertions
  import nsapp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire nsapp_req_t req_i,
  input wire logic req_ready_o,
  input wire logic req_error_o,
  input wire logic busy_o,
  input wire logic write_protect_i,
  input wire logic [7:0] status_byte_o,
  input wire logic status_valid_o,
  input wire logic status_fail_o,
  input wire logic status_fail_prev_o,
  input wire logic array_ready_o,
  input wire logic cache_ready_o,
  input wire logic unprotected_o,
  input wire logic status_rsvd_err_o,
  input wire logic device_ready_o,
  input wire nsapp_pins_t pins_o,
  input wire logic ready_busy_pin_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------
  // Status flags and pins
  // ----------------------------------------
  wp_follow_a: assert property (
    !$past(sys_rst_i) |-> pins_o.wp_n == !$past(write_protect_i))
    else $error("protect pin not following input");
  rsvd_flag_a: assert property (
    status_rsvd_err_o == |(status_byte_o & SB_RSVD_MASK))
    else $error("reserved flag wrong");
  fail_flag_a: assert property (
    status_fail_o == (status_byte_o[0] && status_byte_o[5]))
    else $error("fail flag wrong");
  prev_flag_a: assert property (
    status_fail_prev_o == (status_byte_o[1] && status_byte_o[6]))
    else $error("previous fail flag wrong");
  ready_bits_a: assert property (
    array_ready_o == status_byte_o[5] && cache_ready_o == status_byte_o[6]
    && unprotected_o == status_byte_o[7])
    else $error("ready bits wrong");
  status_strobe_a: assert property (
    status_valid_o |-> $rose(pins_o.re_n) ##1 !status_valid_o)
    else $error("status update off read strobe");
  byte_hold_a: assert property (
    $rose(pins_o.we_n) && !pins_o.ce_n |-> pins_o.io_oe && $stable(pins_o.io_out))
    else $error("bus changed at write strobe rise");
  confirm_wait_a: assert property (
    $rose(pins_o.we_n) && pins_o.cle && pins_o.io_out == CMD_PROG
    |=> (pins_o.we_n && pins_o.re_n) [*4])
    else $error("strobe during program busy");
  busy_cmd_a: assert property (
    $fell(pins_o.we_n) && pins_o.cle && !ready_busy_pin_i
    |-> pins_o.io_out == CMD_STATUS || pins_o.io_out == CMD_RESET)
    else $error("command other than status while busy");
  err_quiet_a: assert property (
    req_error_o |-> pins_o.ce_n
    && $past(req_valid_i && req_ready_o && req_i.op == OP_PROG_BEGIN))
    else $error("refusal without program begin");
  busy_gate_a: assert property (
    req_valid_i && !busy_o && !device_ready_o && req_i.op == OP_PROG_BEGIN |-> !req_ready_o)
    else $error("program taken while device busy");

  cover property (status_valid_o && status_byte_o[0]);
  cover property (req_error_o);
  cover property ($fell(ready_busy_pin_i));
endmodule // nsapp_ctrl_assertions

bind nsapp_ctrl nsapp_ctrl_assertions i_nsapp_ctrl_assertions (.*);

`default_nettype wire

// [sim/nsapp_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none

module nsapp_flash_model
  import nsapp_pkg::*;
#(
  parameter int BUSY_NS = 2000
)
(
  input wire nsapp_pins_t pins_i,
  input wire logic [7:0] bus_i,
  input wire logic fail_i,
  input wire logic bad_id_i,
  output logic [7:0] dq_o,
  output var logic rb_o = 1'b1,
  output var logic [2:0] acnt_o = 3'h0,
  output var logic [15:0] wcol_o = 16'h0000,
  output var logic [7:0] wdat_o = 8'h00
);
  logic smode = 1'b0;
  logic idm = 1'b0;
  logic fl = 1'b0;
  logic [15:0] col = 16'h0000;
  logic [8:0] ptr = 9'h000;
  logic [7:0] last = 8'h00;
  logic [7:0] st;
  logic [7:0] idv;
  logic [7:0] rd;

  // ----------------------------------------
  // Read side
  // ----------------------------------------
  assign st = {pins_i.wp_n, rb_o, rb_o, 3'h0, 1'b0, fl};
  // Copy zero identifier corrupted on request
  assign idv = ptr[4] ? ~{4'hC, ptr[3:0]}
               : {(bad_id_i && ptr[8:5] == 4'h0) ? 4'h3 : 4'hC, ptr[3:0]};
  assign rd = smode ? st : (idm ? idv : 8'h5A);
  // Released bus shows inverse of last value
  assign dq_o = (!pins_i.ce_n && !pins_i.re_n) ? rd : ~last;

  always @(posedge pins_i.re_n) begin
    last <= rd;
    ptr <= idm ? ptr + 9'h001 : 9'h000;
  end

  // ----------------------------------------
  // Write side
  // ----------------------------------------
  always @(posedge pins_i.we_n) begin
    if (!pins_i.ce_n && pins_i.cle) begin
      acnt_o <= 3'h0;
      smode <= bus_i == CMD_STATUS || bus_i == CMD_ENH_STATUS || bus_i == CMD_PROG;
      idm <= bus_i == CMD_ID_PAGE;
      if (bus_i == CMD_PROG) begin
        fl <= fail_i;
        rb_o <= 1'b0;
        rb_o <= #(BUSY_NS) 1'b1;
      end
    end else if (!pins_i.ce_n && pins_i.ale) begin
      acnt_o <= acnt_o + 3'h1;
      if (acnt_o == 3'h0) col[7:0] <= bus_i;
      if (acnt_o == 3'h1) col[15:8] <= bus_i;
    end else if (!pins_i.ce_n) begin
      wcol_o <= col;
      wdat_o <= bus_i;
      col <= col + 16'h0001;
    end
  end
endmodule // nsapp_flash_model

`default_nettype wire

// [sim/nsapp_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module nsapp_ctrl_tb
  import nsapp_pkg::*;
;
  logic clk_i = 1'b0;
  logic sys_rst_i, req_valid_i, req_ready_o, req_error_o, busy_o, write_protect_i;
  nsapp_req_t req_i;
  logic [7:0] status_byte_o, id_rd_data_o, io_i, dq, wdat;
  logic status_valid_o, status_fail_o, status_fail_prev_o, array_ready_o, cache_ready_o;
  logic unprotected_o, status_rsvd_err_o, status_mode_o, device_ready_o, id_done_o, id_ok_o;
  logic ready_busy_pin_i, fail, bad_id, err_seen, sv_seen, rb_low, dn_seen;
  logic [3:0] id_rd_idx_i;
  logic [2:0] acnt;
  logic [15:0] wcol;
  nsapp_pins_t pins_o;
  int n_fail = 0;
  int total_checks = 0;

  always #12.5 clk_i = ~clk_i;
  assign io_i = pins_o.io_oe ? pins_o.io_out : dq;

  nsapp_ctrl i_nsapp_ctrl (.*);
  nsapp_flash_model i_nsapp_flash_model (.pins_i(pins_o), .bus_i(io_i), .fail_i(fail),
    .bad_id_i(bad_id), .dq_o(dq), .rb_o(ready_busy_pin_i), .acnt_o(acnt), .wcol_o(wcol),
    .wdat_o(wdat));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic do_req(input nsapp_op_t op, input logic [15:0] c, input logic [23:0] r,
                        input logic [7:0] d);
    int k;
    k = 0;
    err_seen = 1'b0;
    sv_seen = 1'b0;
    rb_low = 1'b0;
    dn_seen = 1'b0;
    @(posedge clk_i);
    req_i <= '{op: op, col: c, row: r, data: d};
    req_valid_i <= 1'b1;
    do begin
      @(negedge clk_i);
      k++;
    end while (req_ready_o !== 1'b1 && k < 4000);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    do begin
      @(negedge clk_i);
      k++;
      err_seen |= req_error_o;
      sv_seen |= status_valid_o;
      rb_low |= !ready_busy_pin_i;
      dn_seen |= id_done_o;
    end while (busy_o !== 1'b0 && k < 4000);
    if (k >= 4000) begin
      n_fail++;
      $display("ERROR request wait expected done seen timeout");
      final_report();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_status();
    do_req(OP_STATUS, 16'h0000, 24'h000000, 8'h00);
    chk("status pulse", 16'h0001, sv_seen);
    chk("status byte", 16'h00E0, status_byte_o);
    chk("status mode", 16'h0001, status_mode_o);
    chk("ready flags", 16'(3'h7), 16'({unprotected_o, cache_ready_o, array_ready_o}));
    chk("reserved flag", 16'h0000, status_rsvd_err_o);
    @(posedge clk_i);
    write_protect_i <= 1'b1;
    do_req(OP_STATUS, 16'h0000, 24'h000000, 8'h00);
    chk("protected status", 16'h0060, status_byte_o);
    chk("unprotected flag", 16'h0000, unprotected_o);
    @(posedge clk_i);
    write_protect_i <= 1'b0;
    $display("t_status done");
  endtask

  task automatic t_prog();
    fail = 1'b0;
    do_req(OP_PROG_BEGIN, 16'h0010, 24'h000103, 8'h00);
    chk("begin address cycles", 16'h0005, acnt);
    do_req(OP_PROG_DATA, 16'h0010, 24'h000103, 8'h11);
    chk("data column", 16'h0010, wcol);
    chk("data byte", 16'h0011, wdat);
    do_req(OP_RAND_COL, 16'h0040, 24'h000103, 8'h00);
    do_req(OP_PROG_DATA, 16'h0040, 24'h000103, 8'h22);
    chk("moved column", 16'h0040, wcol);
    chk("moved byte", 16'h0022, wdat);
    do_req(OP_PROG_CONFIRM, 16'h0000, 24'h000103, 8'h00);
    chk("busy seen", 16'h0001, rb_low);
    chk("program pass", 16'h00E0, status_byte_o);
    chk("fail flag", 16'h0000, status_fail_o);
    chk("previous fail flag", 16'h0000, status_fail_prev_o);
    chk("device ready", 16'h0001, device_ready_o);
    fail = 1'b1;
    do_req(OP_PROG_BEGIN, 16'h0000, 24'h000104, 8'h00);
    do_req(OP_PROG_CONFIRM, 16'h0000, 24'h000104, 8'h00);
    chk("program fail", 16'h00E1, status_byte_o);
    chk("fail flag", 16'h0001, status_fail_o);
    $display("t_prog done");
  endtask

  task automatic t_order();
    do_req(OP_PROG_BEGIN, 16'h0000, 24'h000102, 8'h00);
    chk("lower page refused", 16'h0001, err_seen);
    for (int i = 0; i < 4; i++) begin
      do_req(OP_PROG_BEGIN, 16'h0000, 24'h000104, 8'h00);
      chk("pass limit", 16'(i == 3), err_seen);
    end
    $display("t_order done");
  endtask

  task automatic t_enh();
    do_req(OP_ENH_STATUS, 16'h0000, 24'h000104, 8'h00);
    chk("row cycles", 16'h0003, acnt);
    chk("plane status", 16'h00E1, status_byte_o);
    chk("status mode", 16'h0001, status_mode_o);
    do_req(OP_READ_MODE, 16'h0000, 24'h000000, 8'h00);
    chk("status mode left", 16'h0000, status_mode_o);
    do_req(OP_STATUS, 16'h0000, 24'h000000, 8'h00);
    chk("status again", 16'h00E1, status_byte_o);
    do_req(OP_RESET, 16'h0000, 24'h000000, 8'h00);
    chk("status mode reset", 16'h0000, status_mode_o);
    $display("t_enh done");
  endtask

  task automatic t_id();
    do_req(OP_ID_CHECK, 16'h0000, 24'h000000, 8'h00);
    chk("identifier good", 16'h0001, id_ok_o);
    chk("identifier done", 16'h0001, dn_seen);
    @(posedge clk_i);
    id_rd_idx_i <= 4'h5;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("identifier byte", 16'h00C5, id_rd_data_o);
    $display("t_id done");
  endtask

  task automatic t_rst();
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk("ready in reset", 16'h0000, device_ready_o);
    do_req(OP_PROG_BEGIN, 16'h0000, 24'h000104, 8'h00);
    chk("begin after reset", 16'h0005, acnt);
    chk("ready after reset", 16'h0001, device_ready_o);
    $display("t_rst done");
  endtask

  initial begin
    sys_rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    write_protect_i = 1'b0;
    id_rd_idx_i = 4'h0;
    fail = 1'b0;
    bad_id = 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_status();
    t_prog();
    t_order();
    t_rst();
    t_enh();
    t_id();
    final_report();
  end
endmodule // nsapp_ctrl_tb

`default_nettype wire
